// [core/mdu_params.svh]
// Purpose: address map, field positions, reset values and cycle counts of the arithmetic unit
// Assumes: included by bare name from the design file
// Notes: definitions only
`ifndef MDU_PARAMS_SVH
`define MDU_PARAMS_SVH

`define MDU_ADDR_W 20
`define MDU_OFS_ACCUM_LO 20'hF00E0
`define MDU_OFS_ACCUM_HI 20'hF00E4
`define MDU_OFS_CTRL 20'hF00E8
`define MDU_OFS_OPA_LO 20'hF00F0
`define MDU_OFS_OPA_HI 20'hF00F4
`define MDU_OFS_PROD_LO 20'hF00F8
`define MDU_OFS_PROD_HI 20'hF00FC

`define MDU_BIT_DIV_SEL 7
`define MDU_BIT_ACC_SEL 6
`define MDU_BIT_SIGNED_SEL 3
`define MDU_BIT_OVERFLOW 2
`define MDU_BIT_SIGN 1
`define MDU_BIT_DIV_RUN 0

`define MDU_CTRL_RST 8'h00
`define MDU_DATA_RST 16'h0000

`define MDU_DIV_LAST_STEP 5'h1F

`endif

// [core/mdu_pkg.sv]
// Purpose: types shared by the arithmetic unit
// Assumes: nothing beyond plain SystemVerilog
// Notes: mode and register selectors only
`default_nettype none

package mdu_pkg;

  typedef enum logic [2:0] {
    MDU_MUL_U,
    MDU_MUL_S,
    MDU_MAC_U,
    MDU_MAC_S,
    MDU_DIV,
    MDU_BAD
  } mdu_mode_e;

  typedef enum logic [2:0] {
    MDU_REG_CTRL,
    MDU_REG_OPA_LO,
    MDU_REG_OPA_HI,
    MDU_REG_PROD_LO,
    MDU_REG_PROD_HI,
    MDU_REG_ACC_LO,
    MDU_REG_ACC_HI,
    MDU_REG_NONE
  } mdu_reg_e;

endpackage : mdu_pkg

`default_nettype wire

// [core/mdu_unit.sv]
// Purpose: 16x16 multiply, 16x16+32 multiply-accumulate and 32/32 unsigned divide on APB
// Assumes: one 20 MHz clock, synchronous active-high reset, APB4 master
// Notes: division is bit-serial, one quotient bit per clock, 32 clocks in all
`default_nettype none
`include "mdu_params.svh"

// Functional notes
// - multiplier from high, multiplicand low, product pair
// - accumulate adds product into accum pair
// - dividend in operand pair, replaced by quotient
// - divisor taken from product pair
// - remainder written into accum pair
// - plain multiply never touches accum pair
// - reset clears all six data registers
// - reset clears control, unsigned multiply selected
// - mode from bits 7,6,3; bits 5,4 zero
// - division done interrupt only when acc_select 0
// - flags at bits 2,1,0; overflow and sign read-only, div_run set by a start write
// - overflow reads 0 after an accumulate without overflow; only accumulate updates it
// - signed modes use two's complement
// - 16-bit data access, 8-bit control access
// - all arithmetic on the one system clock
// - div_run starts, self-clears, sticky while busy
// - multiply one clock, accumulate two clocks
// - overflow sets flag and raises interrupt
// - sign flag follows accum sign, signed accumulate only
module mdu_unit
  import mdu_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`MDU_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic arith_done_irq_o
);

  logic div_select_reg;
  logic acc_select_reg;
  logic signed_select_reg;
  logic overflow_flag_reg;
  logic div_run_reg;
  logic [4:0] div_step_reg;
  logic [15:0] operand_a_low_reg;
  logic [15:0] operand_a_high_reg;
  logic [15:0] product_low_reg;
  logic [15:0] product_high_reg;
  logic [15:0] accum_low_reg;
  logic [15:0] accum_high_reg;
  logic opa_low_seen_reg;
  logic opa_high_seen_reg;
  logic mul_go_reg;
  logic acc_go_reg;

  mdu_mode_e mode;
  mdu_reg_e reg_sel;
  logic access_phase;
  logic bad_access;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_opa_lo;
  logic wr_opa_hi;
  logic wr_prod_lo;
  logic wr_prod_hi;
  logic wr_acc_lo;
  logic wr_acc_hi;
  logic sign_flag;
  logic [7:0] ctrl_read;
  logic [31:0] read_next;
  logic is_mul;
  logic is_mac;
  logic mul_go_next;
  logic div_start;
  logic div_step;
  logic div_done;
  logic [31:0] prod_u;
  logic signed [31:0] prod_s;
  logic [31:0] prod_next;
  logic [31:0] accum_now;
  logic [31:0] product_now;
  logic [32:0] sum_u;
  logic [31:0] acc_sum;
  logic acc_ovf;
  logic [31:0] divisor;
  logic [32:0] rem_shift;
  logic [32:0] rem_diff;
  logic [31:0] rem_next;
  logic [31:0] quo_next;

  localparam logic [7:0] ctrl_rst_val = `MDU_CTRL_RST;

  // bus decode
  always_comb begin
    case (paddr_i)
      `MDU_OFS_CTRL: reg_sel = MDU_REG_CTRL;
      `MDU_OFS_OPA_LO: reg_sel = MDU_REG_OPA_LO;
      `MDU_OFS_OPA_HI: reg_sel = MDU_REG_OPA_HI;
      `MDU_OFS_PROD_LO: reg_sel = MDU_REG_PROD_LO;
      `MDU_OFS_PROD_HI: reg_sel = MDU_REG_PROD_HI;
      `MDU_OFS_ACCUM_LO: reg_sel = MDU_REG_ACC_LO;
      `MDU_OFS_ACCUM_HI: reg_sel = MDU_REG_ACC_HI;
      default: reg_sel = MDU_REG_NONE;
    endcase
  end

  assign access_phase = psel_i & penable_i;

  // data registers need both low lanes, control needs lane 0
  always_comb begin
    bad_access = 1'b0;
    if (reg_sel == MDU_REG_NONE) begin
      bad_access = 1'b1;
    end else if (pwrite_i && reg_sel == MDU_REG_CTRL) begin
      bad_access = ~pstrb_i[0];
    end else if (pwrite_i) begin
      bad_access = (pstrb_i[1:0] != 2'b11);
    end
  end

  // a write lands only at the edge where pready is sampled high
  assign wr_fire = access_phase & pready_o & pwrite_i & ~pslverr_o;
  assign wr_ctrl = wr_fire & (reg_sel == MDU_REG_CTRL);
  assign wr_opa_lo = wr_fire & (reg_sel == MDU_REG_OPA_LO);
  assign wr_opa_hi = wr_fire & (reg_sel == MDU_REG_OPA_HI);
  assign wr_prod_lo = wr_fire & (reg_sel == MDU_REG_PROD_LO);
  assign wr_prod_hi = wr_fire & (reg_sel == MDU_REG_PROD_HI);
  assign wr_acc_lo = wr_fire & (reg_sel == MDU_REG_ACC_LO);
  assign wr_acc_hi = wr_fire & (reg_sel == MDU_REG_ACC_HI);

  always_comb begin
    case ({div_select_reg, acc_select_reg, signed_select_reg})
      3'b000: mode = MDU_MUL_U;
      3'b001: mode = MDU_MUL_S;
      3'b010: mode = MDU_MAC_U;
      3'b011: mode = MDU_MAC_S;
      3'b100, 3'b110: mode = MDU_DIV;
      default: mode = MDU_BAD;
    endcase
  end

  assign is_mul = (mode == MDU_MUL_U) | (mode == MDU_MUL_S);
  assign is_mac = (mode == MDU_MAC_U) | (mode == MDU_MAC_S);
  assign sign_flag = (mode == MDU_MAC_S) & accum_high_reg[15];

  always_comb begin
    ctrl_read = 8'h00;
    ctrl_read[`MDU_BIT_DIV_SEL] = div_select_reg;
    ctrl_read[`MDU_BIT_ACC_SEL] = acc_select_reg;
    ctrl_read[`MDU_BIT_SIGNED_SEL] = signed_select_reg;
    ctrl_read[`MDU_BIT_OVERFLOW] = overflow_flag_reg;
    ctrl_read[`MDU_BIT_SIGN] = sign_flag;
    ctrl_read[`MDU_BIT_DIV_RUN] = div_run_reg;
  end

  always_comb begin
    case (reg_sel)
      MDU_REG_CTRL: read_next = {24'h000000, ctrl_read};
      MDU_REG_OPA_LO: read_next = {16'h0000, operand_a_low_reg};
      MDU_REG_OPA_HI: read_next = {16'h0000, operand_a_high_reg};
      MDU_REG_PROD_LO: read_next = {16'h0000, product_low_reg};
      MDU_REG_PROD_HI: read_next = {16'h0000, product_high_reg};
      MDU_REG_ACC_LO: read_next = {16'h0000, accum_low_reg};
      MDU_REG_ACC_HI: read_next = {16'h0000, accum_high_reg};
      default: read_next = 32'h0000_0000;
    endcase
  end

  // one wait cycle: pready rises on the first access cycle, falls after the handshake
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (access_phase && !pready_o) begin
      pready_o <= 1'b1;
      pslverr_o <= bad_access;
      prdata_o <= pwrite_i ? 32'h0000_0000 : read_next;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // mode bits; overflow and sign flags are not software-writable, div_run is set only by a start write
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_select_reg <= ctrl_rst_val[`MDU_BIT_DIV_SEL];
      acc_select_reg <= ctrl_rst_val[`MDU_BIT_ACC_SEL];
      signed_select_reg <= ctrl_rst_val[`MDU_BIT_SIGNED_SEL];
    end else if (wr_ctrl) begin
      div_select_reg <= pwdata_i[`MDU_BIT_DIV_SEL];
      acc_select_reg <= pwdata_i[`MDU_BIT_ACC_SEL];
      signed_select_reg <= pwdata_i[`MDU_BIT_SIGNED_SEL];
    end
  end

  // start only if the value being written itself selects division
  assign div_start = wr_ctrl & ~div_run_reg & pwdata_i[`MDU_BIT_DIV_RUN]
                     & pwdata_i[`MDU_BIT_DIV_SEL] & ~pwdata_i[`MDU_BIT_SIGNED_SEL];
  assign div_step = div_run_reg;
  assign div_done = div_run_reg & (div_step_reg == `MDU_DIV_LAST_STEP);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_run_reg <= 1'b0;
    end else if (div_done) begin
      div_run_reg <= 1'b0;
    end else if (div_start) begin
      div_run_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_step_reg <= 5'h00;
    end else if (div_start) begin
      div_step_reg <= 5'h00;
    end else if (div_step) begin
      div_step_reg <= div_step_reg + 5'h01;
    end
  end

  // restoring divider step, quotient bits shift into the dividend pair
  assign divisor = {product_high_reg, product_low_reg};
  assign accum_now = {accum_high_reg, accum_low_reg};
  assign rem_shift = {accum_now, operand_a_high_reg[15]};
  assign rem_diff = rem_shift - {1'b0, divisor};
  assign rem_next = rem_diff[32] ? rem_shift[31:0] : rem_diff[31:0];
  assign quo_next = {operand_a_high_reg[14:0], operand_a_low_reg, ~rem_diff[32]};

  // plain multiply waits for both halves; accumulate is kicked by the high half
  assign mul_go_next = (is_mul & (wr_opa_lo | wr_opa_hi)
                        & (wr_opa_lo | opa_low_seen_reg) & (wr_opa_hi | opa_high_seen_reg))
                       | (is_mac & wr_opa_hi);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      opa_low_seen_reg <= 1'b0;
      opa_high_seen_reg <= 1'b0;
    end else if (mul_go_next) begin
      opa_low_seen_reg <= 1'b0;
      opa_high_seen_reg <= 1'b0;
    end else if (is_mul) begin
      opa_low_seen_reg <= opa_low_seen_reg | wr_opa_lo;
      opa_high_seen_reg <= opa_high_seen_reg | wr_opa_hi;
    end else begin
      // halves written in other modes must not half-arm a later multiply
      opa_low_seen_reg <= 1'b0;
      opa_high_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mul_go_reg <= 1'b0;
      acc_go_reg <= 1'b0;
    end else begin
      mul_go_reg <= mul_go_next;
      acc_go_reg <= mul_go_reg & is_mac;
    end
  end

  assign prod_u = {16'h0000, operand_a_high_reg} * {16'h0000, operand_a_low_reg};
  assign prod_s = $signed({{16{operand_a_high_reg[15]}}, operand_a_high_reg})
                  * $signed({{16{operand_a_low_reg[15]}}, operand_a_low_reg});
  assign prod_next = signed_select_reg ? prod_s : prod_u;

  // accumulate uses the product latched one clock earlier
  assign product_now = {product_high_reg, product_low_reg};
  assign sum_u = {1'b0, accum_now} + {1'b0, product_now};
  assign acc_sum = sum_u[31:0];
  assign acc_ovf = signed_select_reg
                   ? (accum_now[31] == product_now[31]) & (acc_sum[31] != accum_now[31])
                   : sum_u[32];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      overflow_flag_reg <= 1'b0;
    end else if (acc_go_reg) begin
      overflow_flag_reg <= acc_ovf;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      arith_done_irq_o <= 1'b0;
    end else begin
      arith_done_irq_o <= (div_done & ~acc_select_reg) | (acc_go_reg & acc_ovf);
    end
  end

  // bus writes during a division are undefined by contract; the divider wins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      operand_a_low_reg <= `MDU_DATA_RST;
      operand_a_high_reg <= `MDU_DATA_RST;
    end else if (div_step) begin
      {operand_a_high_reg, operand_a_low_reg} <= quo_next;
    end else begin
      if (wr_opa_lo) begin
        operand_a_low_reg <= pwdata_i[15:0];
      end
      if (wr_opa_hi) begin
        operand_a_high_reg <= pwdata_i[15:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      product_low_reg <= `MDU_DATA_RST;
      product_high_reg <= `MDU_DATA_RST;
    end else if (mul_go_reg) begin
      {product_high_reg, product_low_reg} <= prod_next;
    end else begin
      if (wr_prod_lo) begin
        product_low_reg <= pwdata_i[15:0];
      end
      if (wr_prod_hi) begin
        product_high_reg <= pwdata_i[15:0];
      end
    end
  end

  // only division, accumulate and bus writes touch this pair, never plain multiply
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      accum_low_reg <= `MDU_DATA_RST;
      accum_high_reg <= `MDU_DATA_RST;
    end else if (div_start) begin
      {accum_high_reg, accum_low_reg} <= 32'h0000_0000;
    end else if (div_step) begin
      {accum_high_reg, accum_low_reg} <= rem_next;
    end else if (acc_go_reg) begin
      {accum_high_reg, accum_low_reg} <= acc_sum;
    end else begin
      if (wr_acc_lo) begin
        accum_low_reg <= pwdata_i[15:0];
      end
      if (wr_acc_hi) begin
        accum_high_reg <= pwdata_i[15:0];
      end
    end
  end

endmodule : mdu_unit

`default_nettype wire

// [sim/mdu_unit_properties.sv]
// Purpose: port-level checks of the arithmetic unit
// Assumes: one clock, synchronous active-high reset
// Notes: a small counter shadows the division so its end can be timed
`default_nettype none
`include "mdu_params.svh"
module mdu_unit_properties (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`MDU_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic arith_done_irq_o
);
  logic [5:0] div_cnt;
  logic acc;
  logic div_go;
  assign acc = psel_i && penable_i && pready_o;
  // a start while busy is ignored by the unit, so the shadow ignores it too
  assign div_go = acc && pwrite_i && paddr_i == `MDU_OFS_CTRL && pstrb_i[0] && pwdata_i[7] && !pwdata_i[3]
    && pwdata_i[0] && div_cnt == 6'h00;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_cnt <= 6'h00;
    end else if (div_go) begin
      div_cnt <= 6'h21;
    end else if (div_cnt != 6'h00) begin
      div_cnt <= div_cnt - 6'h01;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready longer than one cycle");
  ready_timing_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready late");
  err_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
  ctrl_zero_a: assert property (acc && !pwrite_i && paddr_i == `MDU_OFS_CTRL
    |-> prdata_o[31:8] == 24'h000000 && prdata_o[5:4] == 2'h0) else $error("control reserved bits set");
  data_width_a: assert property (acc && !pwrite_i && paddr_i != `MDU_OFS_CTRL && !pslverr_o
    |-> prdata_o[31:16] == 16'h0000) else $error("data upper half set");
  div_irq_a: assert property (div_go && !pwdata_i[6] |-> ##33 arith_done_irq_o) else $error("no divide irq");
  div_quiet_a: assert property (div_go && pwdata_i[6] |-> ##33 !arith_done_irq_o) else $error("divide irq");
  div_busy_a: assert property (acc && !pwrite_i && paddr_i == `MDU_OFS_CTRL && div_cnt > 6'h02
    && div_cnt < 6'h1F |-> prdata_o[0]) else $error("div_run low while busy");
  irq_pulse_a: assert property (arith_done_irq_o |=> !arith_done_irq_o) else $error("irq too long");
endmodule : mdu_unit_properties
bind mdu_unit mdu_unit_properties u_props (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .arith_done_irq_o);
`default_nettype wire

// [sim/tb_mul_div_mac_unit.sv]
// Purpose: directed bench of the arithmetic unit over APB
// Assumes: 20 MHz clock, reset held four cycles
// Notes: a hung transfer ends the run
`default_nettype none
`include "mdu_params.svh"
module tb_mul_div_mac_unit;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [19:0] paddr_i = 20'h00000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [3:0] pstrb_i = 4'hF;
  wire logic [31:0] prdata_o;
  wire logic pready_o;
  wire logic pslverr_o;
  wire logic arith_done_irq_o;
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int n_tests = 0;
  int irqs = 0;
  int n;
  mdu_unit u_dut (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .arith_done_irq_o);
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (arith_done_irq_o === 1'b1) irqs++;
  end
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [19:0] a, input logic [15:0] d);
    int i;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {16'h0000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    i = 0;
    // request held until pready is seen at a rising edge
    do begin
      @(posedge clk_i);
      i++;
    end while (pready_o !== 1'b1 && i < 20);
    if (i >= 20) begin
      num_errors++;
      tally_and_finish();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [19:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    chk(rd, {16'h0000, e});
  endtask : rc
  task automatic t_reset;
    rc(`MDU_OFS_CTRL, 16'h0000);
    rc(`MDU_OFS_OPA_LO, 16'h0000);
    rc(`MDU_OFS_PROD_HI, 16'h0000);
    rc(`MDU_OFS_ACCUM_HI, 16'h0000);
    apb(1'b0, 20'hF00EC, 16'h0000);
    chk({31'h0, er}, 32'h1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_mul;
    wr(`MDU_OFS_CTRL, 16'h0001);
    rc(`MDU_OFS_CTRL, 16'h0000);
    wr(`MDU_OFS_ACCUM_LO, 16'h5678);
    wr(`MDU_OFS_ACCUM_HI, 16'h1234);
    wr(`MDU_OFS_OPA_LO, 16'hFFFF);
    wr(`MDU_OFS_OPA_HI, 16'hFFFF);
    rc(`MDU_OFS_PROD_HI, 16'hFFFE);
    rc(`MDU_OFS_PROD_LO, 16'h0001);
    wr(`MDU_OFS_CTRL, 16'h0008);
    wr(`MDU_OFS_OPA_LO, 16'hFFFE);
    wr(`MDU_OFS_OPA_HI, 16'h7FFF);
    rc(`MDU_OFS_PROD_HI, 16'hFFFF);
    rc(`MDU_OFS_PROD_LO, 16'h0002);
    rc(`MDU_OFS_ACCUM_LO, 16'h5678);
    pstrb_i <= 4'h1;
    wr(`MDU_OFS_PROD_LO, 16'h0000);
    chk({31'h0, er}, 32'h1);
    pstrb_i <= 4'hF;
    rc(`MDU_OFS_PROD_LO, 16'h0002);
    $display("multiply test done");
  endtask : t_mul
  task automatic mac(input logic [15:0] h, input logic [15:0] l, input logic [15:0] b, input logic [15:0] c);
    wr(`MDU_OFS_ACCUM_HI, h);
    wr(`MDU_OFS_ACCUM_LO, l);
    wr(`MDU_OFS_OPA_LO, b);
    wr(`MDU_OFS_OPA_HI, c);
  endtask : mac
  task automatic t_mac;
    wr(`MDU_OFS_CTRL, 16'h0040);
    mac(16'h0000, 16'h0003, 16'h0002, 16'h0003);
    rc(`MDU_OFS_ACCUM_LO, 16'h0009);
    rc(`MDU_OFS_PROD_LO, 16'h0006);
    n = irqs;
    mac(16'hFFFF, 16'h0002, 16'h7FFF, 16'h0002);
    rc(`MDU_OFS_ACCUM_LO, 16'h0000);
    rc(`MDU_OFS_ACCUM_HI, 16'h0000);
    chk(irqs - n, 1);
    wr(`MDU_OFS_CTRL, 16'h0042);
    rc(`MDU_OFS_CTRL, 16'h0044);
    mac(16'h0000, 16'h0000, 16'h0001, 16'h0001);
    rc(`MDU_OFS_CTRL, 16'h0040);
    wr(`MDU_OFS_CTRL, 16'h0048);
    mac(16'hFFFF, 16'hFFF0, 16'h0002, 16'h0003);
    rc(`MDU_OFS_ACCUM_LO, 16'hFFF6);
    rc(`MDU_OFS_CTRL, 16'h004A);
    mac(16'h7FFF, 16'hFFFF, 16'h0001, 16'h0001);
    rc(`MDU_OFS_CTRL, 16'h004E);
    $display("accumulate test done");
  endtask : t_mac
  task automatic t_div;
    wr(`MDU_OFS_CTRL, 16'h0080);
    wr(`MDU_OFS_OPA_HI, 16'h0001);
    wr(`MDU_OFS_OPA_LO, 16'h86A0);
    wr(`MDU_OFS_PROD_HI, 16'h0000);
    wr(`MDU_OFS_PROD_LO, 16'h0007);
    n = irqs;
    wr(`MDU_OFS_CTRL, 16'h0081);
    wr(`MDU_OFS_CTRL, 16'h0080);
    rc(`MDU_OFS_CTRL, 16'h0085);
    // divide length is fixed at 32 clocks, so a fixed wait is enough
    repeat (40) @(posedge clk_i);
    rc(`MDU_OFS_OPA_LO, 16'h37CD);
    rc(`MDU_OFS_ACCUM_LO, 16'h0005);
    rc(`MDU_OFS_CTRL, 16'h0084);
    chk(irqs - n, 1);
    wr(`MDU_OFS_OPA_HI, 16'hFFFF);
    wr(`MDU_OFS_OPA_LO, 16'hFFFF);
    wr(`MDU_OFS_PROD_HI, 16'h0001);
    wr(`MDU_OFS_PROD_LO, 16'h0000);
    n = irqs;
    wr(`MDU_OFS_CTRL, 16'h00C1);
    repeat (40) @(posedge clk_i);
    rc(`MDU_OFS_OPA_HI, 16'h0000);
    rc(`MDU_OFS_OPA_LO, 16'hFFFF);
    rc(`MDU_OFS_ACCUM_LO, 16'hFFFF);
    chk(irqs - n, 0);
    // signed divide is a prohibited mode: no start, flags as before
    wr(`MDU_OFS_CTRL, 16'h0089);
    rc(`MDU_OFS_CTRL, 16'h008C);
    $display("divide test done");
  endtask : t_div
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_mul();
    t_mac();
    t_div();
    tally_and_finish();
  end
endmodule : tb_mul_div_mac_unit
`default_nettype wire
